// ### rtc_i2c_defs.svh
// Constants shared by both ends of the RTC two-wire serial link.
`ifndef RTC_I2C_DEFS_SVH
`define RTC_I2C_DEFS_SVH

// Fixed 7-bit bus address of the clock device.
`define I2C_DEV_ADDR        7'h68
// Direction bit values carried in the address byte.
`define I2C_DIR_WRITE       1'h0
`define I2C_DIR_READ        1'h1

// Register map of the device: implemented addresses 0 to 9.
`define REG_COUNT           8'h0A
`define REG_LAST            4'h9
`define REG_SECONDS         4'h0
`define REG_CONTROL         4'h7
`define REG_FIRST           4'h0

// Reset values of the mirrored registers.
`define CTRL_RESET          8'h80
`define REG_RESET           8'h00

// Bit index of the acknowledge bit within a byte slot (data bits are 0 to 7).
`define ACK_SLOT            4'h8

// Timing: system clock period and the shortest serial clock period allowed.
`define SYS_CLK_PERIOD_NS   40
`define I2C_SCL_MIN_PERIOD_NS 2500
// A quarter of the serial clock period in system clock cycles, rounded up.
`define I2C_QUARTER_CYC     ((`I2C_SCL_MIN_PERIOD_NS + 4 * `SYS_CLK_PERIOD_NS - 1) / (4 * `SYS_CLK_PERIOD_NS))

`endif

// ### rtc_i2c_pkg.sv
// Types shared by both ends of the RTC two-wire serial link.
`default_nettype none
package rtc_i2c_pkg;

  // Transfer phase of the device end.
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WDATA, PH_RDATA} dev_phase_type;

  // Commands accepted by the controlling end.
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} mst_op_type;

  // Sequencer states of the controlling end.
  typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BIT} mst_state_type;

endpackage
`default_nettype wire

// ### i2c_link_if.sv
// Open-drain two-wire link joining the controlling end and the clock device.
`timescale 1ns/1ns
`default_nettype none
interface i2c_link_if;

  logic      sclOut;
  logic      sclOe;
  logic      sdaMstOut;
  logic      sdaMstOe;
  logic      sdaDevOut;
  logic      sdaDevOe;
  wire logic scl;
  wire logic sda;

  // Wired-AND: a line is low while any enabled driver pulls it low.
  assign scl = !(sclOe && !sclOut);
  assign sda = !((sdaMstOe && !sdaMstOut) || (sdaDevOe && !sdaDevOut));

  modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport host (input scl, input sda, output sclOut, output sclOe,
                output sdaMstOut, output sdaMstOe);

endinterface
`default_nettype wire

// ### rtc_i2c_host.sv
// Controlling end of the serial link: makes the clock and all bus conditions.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_i2c_defs.svh"
module rtc_i2c_host
  import rtc_i2c_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  i2c_link_if.host         link,
  input  wire logic        cmdValid,
  input  wire mst_op_type  cmdOp,
  input  wire logic [7:0]  cmdData,
  input  wire logic        cmdNack,
  output logic             cmdReady,
  output logic             rspValid,
  output logic [7:0]       rspData,
  output logic             rspAck,
  output logic             busIdle
);

  localparam logic [4:0] QEND = 5'(`I2C_QUARTER_CYC - 1);

  mst_state_type state_ff;
  logic [1:0]    lineSync1_ff;
  logic [1:0]    lineSync2_ff;
  logic          busIdle_ff;
  logic [4:0]    qCnt_ff;
  logic [1:0]    q_ff;
  logic [3:0]    bitIdx_ff;
  logic [7:0]    txShift_ff;
  logic [7:0]    rxShift_ff;
  logic          ackBit_ff;
  logic          isRead_ff;
  logic          nack_ff;
  logic          open_ff;
  logic          sclOe_ff;
  logic          sdaOe_ff;
  logic          cmdReady_ff;
  logic          rspValid_ff;
  logic [7:0]    rspData_ff;
  logic          rspAck_ff;
  logic          tick;
  logic          accept;

  // Both lines pass two flip-flops; the first stage is read by nothing else.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lineSync1_ff <= 2'h3;
      lineSync2_ff <= 2'h3;
      busIdle_ff   <= 1'b0;
    end
    else
    begin
      lineSync1_ff <= {link.sda, link.scl};
      lineSync2_ff <= lineSync1_ff;
      busIdle_ff   <= &lineSync2_ff;
    end
  end

  // A START is taken from an idle bus or an open transfer; other commands need an open one.
  assign tick   = (qCnt_ff == QEND);
  assign accept = cmdReady_ff && cmdValid &&
                  ((cmdOp == OP_START) ? (open_ff || busIdle_ff) : open_ff);

  // Quarter-period divider; every line change lands on a quarter boundary.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      qCnt_ff <= 5'h00;
      q_ff    <= 2'h0;
    end
    else if (state_ff == M_IDLE)
    begin
      qCnt_ff <= 5'h00;
      q_ff    <= 2'h0;
    end
    else if (tick)
    begin
      qCnt_ff <= 5'h00;
      q_ff    <= q_ff + 2'h1;
    end
    else
    begin
      qCnt_ff <= qCnt_ff + 5'h01;
    end
  end

  // Sequencer. Data moves a quarter after the clock falls, so no edge on the
  // data line can ever be mistaken for a condition while the clock is high.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff    <= M_IDLE;
      bitIdx_ff   <= 4'h0;
      txShift_ff  <= 8'h00;
      rxShift_ff  <= 8'h00;
      ackBit_ff   <= 1'b1;
      isRead_ff   <= 1'b0;
      nack_ff     <= 1'b0;
      open_ff     <= 1'b0;
      sclOe_ff    <= 1'b0;
      sdaOe_ff    <= 1'b0;
      cmdReady_ff <= 1'b0;
      rspValid_ff <= 1'b0;
      rspData_ff  <= 8'h00;
      rspAck_ff   <= 1'b0;
    end
    else
    begin
      rspValid_ff <= 1'b0;
      case (state_ff)
        M_IDLE:
        begin
          cmdReady_ff <= 1'b1;
          if (accept)
          begin
            cmdReady_ff <= 1'b0;
            txShift_ff  <= cmdData;
            isRead_ff   <= (cmdOp == OP_READ);
            nack_ff     <= cmdNack;
            bitIdx_ff   <= 4'h0;
            case (cmdOp)
              OP_START: state_ff <= M_START;
              OP_STOP:  state_ff <= M_STOP;
              default:  state_ff <= M_BIT;
            endcase
          end
        end
        M_START:
        begin
          if (tick)
          begin
            case (q_ff)
              2'h0: sdaOe_ff <= 1'b0;
              2'h1: sclOe_ff <= 1'b0;
              2'h2: sdaOe_ff <= 1'b1;
              default:
              begin
                sclOe_ff <= 1'b1;
                open_ff  <= 1'b1;
                state_ff <= M_IDLE;
              end
            endcase
          end
        end
        M_STOP:
        begin
          if (tick)
          begin
            case (q_ff)
              2'h0: sdaOe_ff <= 1'b1;
              2'h1: sclOe_ff <= 1'b0;
              2'h2: sdaOe_ff <= 1'b0;
              default:
              begin
                open_ff  <= 1'b0;
                state_ff <= M_IDLE;
              end
            endcase
          end
        end
        default:
        begin
          if (tick)
          begin
            case (q_ff)
              2'h0:
              begin
                if (bitIdx_ff == `ACK_SLOT)
                  sdaOe_ff <= isRead_ff && !nack_ff;
                else
                  sdaOe_ff <= !isRead_ff && !txShift_ff[7];
              end
              2'h1: sclOe_ff <= 1'b0;
              2'h2:
              begin
                if (bitIdx_ff == `ACK_SLOT)
                  ackBit_ff <= lineSync2_ff[1];
                else
                  rxShift_ff <= {rxShift_ff[6:0], lineSync2_ff[1]};
              end
              default:
              begin
                sclOe_ff <= 1'b1;
                if (bitIdx_ff == `ACK_SLOT)
                begin
                  rspValid_ff <= 1'b1;
                  rspData_ff  <= rxShift_ff;
                  rspAck_ff   <= !ackBit_ff;
                  state_ff    <= M_IDLE;
                end
                else
                begin
                  txShift_ff <= {txShift_ff[6:0], 1'b0};
                  bitIdx_ff  <= bitIdx_ff + 4'h1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // Open-drain pins only ever pull low.
  assign link.sclOut    = 1'b0;
  assign link.sdaMstOut = 1'b0;
  assign link.sclOe     = sclOe_ff;
  assign link.sdaMstOe  = sdaOe_ff;
  assign cmdReady       = cmdReady_ff;
  assign rspValid       = rspValid_ff;
  assign rspData        = rspData_ff;
  assign rspAck         = rspAck_ff;
  assign busIdle        = busIdle_ff;

endmodule // rtc_i2c_host
`default_nettype wire

// ### rtc_i2c_device.sv
// Clock-device end of the serial link: address match, pointer and data bytes.
//
// Behaviour
// - Bus idle only while both lines high.
// - Data falling while clock high is START.
// - Data rising while clock high is STOP.
// - Data changes only while clock low.
// - Bytes of eight bits, ninth bit acknowledges.
// - Acknowledger holds data low through clock high.
// - Device releases data after master's not-acknowledge.
// - Master makes all clocks and bus conditions.
// - Repeated START ends and opens transfers immediately.
// - Works at standard and fast clock rates.
// - First byte after START is the address.
// - Match fixed address; direction zero means write.
// - Direction one means device transmits data.
// - Acknowledge a matching address byte.
// - First written byte loads the register pointer.
// - Acknowledge data bytes; pointer advances each byte.
// - Reads start at current, possibly stale, pointer.
// - Device transmits until master sends not-acknowledge.
// - Written byte commits at its acknowledge.
// - Refresh time copies on START, STOP, wrap.
// - Writing seconds resets the divider chain.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_i2c_defs.svh"
module rtc_i2c_device
  import rtc_i2c_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  i2c_link_if.device       link,
  output logic             wrStrobe,
  output logic [3:0]       wrAddr,
  output logic [7:0]       wrData,
  output logic             snapReq,
  output logic             divReset
);

  // Pointer step with wrap at the top of the map.
  function automatic logic [3:0] ptrInc(input logic [3:0] p);
    ptrInc = (p == `REG_LAST) ? `REG_FIRST : (p + 4'h1);
  endfunction

  // A loaded pointer beyond the map falls back to the first register.
  function automatic logic [3:0] ptrLoad(input logic [7:0] b);
    ptrLoad = (b < `REG_COUNT) ? b[3:0] : `REG_FIRST;
  endfunction

  logic          startTgl_ff;
  logic          stopTgl_ff;
  logic          startSeen_ff;
  dev_phase_type phase_ff;
  logic [3:0]    bitCnt_ff;
  logic [7:0]    shift_ff;
  logic [7:0]    txByte_ff;
  logic [3:0]    ptr_ff;
  logic          ackFlag_ff;
  logic          sdaOe_ff;
  logic          wrTgl_ff;
  logic          wrapTgl_ff;
  logic [3:0]    wrAddrL_ff;
  logic [7:0]    wrDataL_ff;
  logic [7:0]    regMem [0:`REG_LAST];
  logic [3:0]    tglSync1_ff;
  logic [3:0]    tglSync2_ff;
  logic [3:0]    tglPrev_ff;
  logic          wrStrobe_ff;
  logic [3:0]    wrAddr_ff;
  logic [7:0]    wrData_ff;
  logic          snapReq_ff;
  logic          divReset_ff;
  logic          newFrame;
  logic [7:0]    rxByte;
  logic [3:0]    tglEdge;
  logic          byteEnd;

  // Conditions are seen on the data line's own edges, since the clock is
  // high and still throughout; each flips a toggle that others compare.
  always_ff @(negedge link.sda or posedge rst)
  begin
    if (rst)
      startTgl_ff <= 1'b0;
    else if (link.scl)
      startTgl_ff <= !startTgl_ff;
  end

  // The clock stands still after a STOP, so it is handed to the system side.
  always_ff @(posedge link.sda or posedge rst)
  begin
    if (rst)
      stopTgl_ff <= 1'b0;
    else if (link.scl)
      stopTgl_ff <= !stopTgl_ff;
  end

  // A START not yet taken up marks the rising clock edge as bit 0 of the
  // address byte; it also cuts off whatever the old transfer was doing.
  assign newFrame = (startTgl_ff != startSeen_ff);
  assign rxByte   = {shift_ff[6:0], link.sda};
  assign byteEnd  = !newFrame && (bitCnt_ff == `ACK_SLOT);

  // Bit and phase sequencing on the rising serial clock. Being clocked by
  // the link itself, it keeps pace with any clock rate the master picks.
  always_ff @(posedge link.scl or posedge rst)
  begin
    if (rst)
    begin
      {startSeen_ff, ackFlag_ff} <= 2'h0;
      phase_ff     <= PH_IDLE;
      bitCnt_ff    <= 4'h0;
      shift_ff     <= 8'h00;
    end
    else if (newFrame)
    begin
      startSeen_ff <= startTgl_ff;
      phase_ff     <= PH_ADDR;
      bitCnt_ff    <= 4'h1;
      shift_ff     <= {7'h00, link.sda};
      ackFlag_ff   <= 1'b0;
    end
    else if (phase_ff != PH_IDLE)
    begin
      if (bitCnt_ff != `ACK_SLOT)
      begin
        shift_ff  <= rxByte;
        bitCnt_ff <= bitCnt_ff + 4'h1;
        if (bitCnt_ff == 4'h7)
          ackFlag_ff <= (phase_ff == PH_PTR) || (phase_ff == PH_WDATA) ||
                        ((phase_ff == PH_ADDR) && (rxByte[7:1] == `I2C_DEV_ADDR));
      end
      else
      begin
        bitCnt_ff  <= 4'h0;
        ackFlag_ff <= 1'b0;
        case (phase_ff)
          PH_ADDR:
          begin
            if (!ackFlag_ff)
              phase_ff <= PH_IDLE;
            else if (shift_ff[0] == `I2C_DIR_READ)
              phase_ff <= PH_RDATA;
            else
              phase_ff <= PH_PTR;
          end
          PH_PTR:   phase_ff <= PH_WDATA;
          PH_WDATA: phase_ff <= PH_WDATA;
          PH_RDATA:
          begin
            if (link.sda)
              phase_ff <= PH_IDLE;
          end
          default:  phase_ff <= PH_IDLE;
        endcase
      end
    end
  end

  // Pointer and transmit byte, both updated in the acknowledge clock.
  always_ff @(posedge link.scl or posedge rst)
  begin
    if (rst)
    begin
      {ptr_ff, txByte_ff, wrapTgl_ff} <= {`REG_FIRST, 8'h00, 1'b0};
    end
    else if (byteEnd)
    begin
      case (phase_ff)
        PH_ADDR:
        begin
          if (ackFlag_ff && (shift_ff[0] == `I2C_DIR_READ))
            txByte_ff <= regMem[ptr_ff];
        end
        PH_PTR: ptr_ff <= ptrLoad(shift_ff);
        PH_WDATA: ptr_ff <= ptrInc(ptr_ff);
        PH_RDATA:
        begin
          ptr_ff <= ptrInc(ptr_ff);
          if (!link.sda)
            txByte_ff <= regMem[ptrInc(ptr_ff)];
        end
        default: ptr_ff <= ptr_ff;
      endcase
      if (((phase_ff == PH_WDATA) || (phase_ff == PH_RDATA)) && (ptr_ff == `REG_LAST))
        wrapTgl_ff <= !wrapTgl_ff;
    end
  end

  // Register image. A data byte lands in its register in the acknowledge
  // clock and is posted to the system side with a toggle.
  always_ff @(posedge link.scl or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i <= int'(`REG_LAST); i++)
        regMem[i] <= (i == int'(`REG_CONTROL)) ? `CTRL_RESET : `REG_RESET;
      {wrTgl_ff, wrAddrL_ff, wrDataL_ff} <= {1'b0, `REG_FIRST, 8'h00};
    end
    else if (byteEnd && (phase_ff == PH_WDATA))
    begin
      regMem[ptr_ff] <= shift_ff;
      wrAddrL_ff     <= ptr_ff;
      wrDataL_ff     <= shift_ff;
      wrTgl_ff       <= !wrTgl_ff;
    end
  end

  // Drive changes on the falling clock only; a pending START keeps the line
  // released so that a stale read phase cannot trample the next address.
  always_ff @(negedge link.scl or posedge rst)
  begin
    if (rst)
      sdaOe_ff <= 1'b0;
    else if (newFrame)
      sdaOe_ff <= 1'b0;
    else if ((phase_ff == PH_RDATA) && (bitCnt_ff != `ACK_SLOT))
      sdaOe_ff <= !txByte_ff[~bitCnt_ff[2:0]];
    else
      sdaOe_ff <= (bitCnt_ff == `ACK_SLOT) && ackFlag_ff;
  end

  // Link events into the system clock: two flip-flops per toggle, then an
  // edge against the previous value. Latched words are stable by then.
  assign tglEdge = tglSync2_ff ^ tglPrev_ff;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {tglSync1_ff, tglSync2_ff, tglPrev_ff} <= 12'h000;
    end
    else
    begin
      tglSync1_ff <= {wrTgl_ff, wrapTgl_ff, stopTgl_ff, startTgl_ff};
      tglSync2_ff <= tglSync1_ff;
      tglPrev_ff  <= tglSync2_ff;
    end
  end

  // User-side pulses: committed writes, copy refresh and divider reset.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {wrStrobe_ff, snapReq_ff, divReset_ff} <= 3'h0;
      {wrAddr_ff, wrData_ff} <= {`REG_FIRST, 8'h00};
    end
    else
    begin
      wrStrobe_ff <= tglEdge[3];
      snapReq_ff  <= |tglEdge[2:0];
      divReset_ff <= tglEdge[3] &&
                     ((wrAddrL_ff == `REG_SECONDS) || (wrAddrL_ff == `REG_CONTROL));
      if (tglEdge[3])
      begin
        wrAddr_ff <= wrAddrL_ff;
        wrData_ff <= wrDataL_ff;
      end
    end
  end

  // The device only ever pulls the data line low.
  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe  = sdaOe_ff;
  assign wrStrobe       = wrStrobe_ff;
  assign wrAddr         = wrAddr_ff;
  assign wrData         = wrData_ff;
  assign snapReq        = snapReq_ff;
  assign divReset       = divReset_ff;

endmodule // rtc_i2c_device
`default_nettype wire

// ### rtc_i2c_slave_interface_assertions.sv
// Concurrent checks on the two-wire link between the host end and the clock device.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_i2c_defs.svh"
module rtc_i2c_slave_interface_assertions
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sdaDevOe,
  input wire logic scl,
  input wire logic sda
);
  logic       sclQ_ff;
  logic       sdaQ_ff;
  logic       first_ff;
  logic       hit_ff;
  logic       rd_ff;
  logic       nack_ff;
  logic [3:0] bits_ff;
  logic [6:0] shift_ff;
  logic       rise;
  logic       startEv;
  logic       stopEv;
  logic       ackSlot;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Line events seen on the system clock, which is the clock the host moves the lines on.
  assign rise    = scl && !sclQ_ff;
  assign startEv = scl && sclQ_ff && sdaQ_ff && !sda;
  assign stopEv  = scl && sclQ_ff && !sdaQ_ff && sda;
  assign ackSlot = rise && bits_ff == 4'h8;

  // Frame tracking; a STOP clears the match, so a device left driving is caught.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {sclQ_ff, sdaQ_ff} <= 2'h3;
      {first_ff, hit_ff, rd_ff, nack_ff} <= 4'h0;
      bits_ff <= 4'h0;
      shift_ff <= 7'h00;
    end
    else
    begin
      sclQ_ff <= scl;
      sdaQ_ff <= sda;
      if (startEv)
      begin
        bits_ff <= 4'h0;
        first_ff <= 1'b1;
        nack_ff <= 1'b0;
      end
      else if (rise)
      begin
        bits_ff <= ackSlot ? 4'h0 : bits_ff + 4'h1;
        shift_ff <= {shift_ff[5:0], sda};
        first_ff <= first_ff && !ackSlot;
        if (bits_ff == 4'h7 && first_ff)
        begin
          hit_ff <= shift_ff == `I2C_DEV_ADDR;
          rd_ff <= sda;
        end
        if (ackSlot && !first_ff && hit_ff && rd_ff && sda)
          nack_ff <= 1'b1;
      end
      if (stopEv)
        hit_ff <= 1'b0;
    end
  end

  a_addr_ack: assert property (ackSlot && first_ff |-> sdaDevOe == hit_ff)
    else $error("address acknowledge wrong");
  a_data_ack: assert property (ackSlot && !first_ff && hit_ff && !rd_ff |-> sdaDevOe)
    else $error("written byte not acknowledged");
  a_miss_quiet: assert property (!hit_ff |-> !sdaDevOe)
    else $error("device drives data while not addressed");
  a_nack_release: assert property (nack_ff |-> !sdaDevOe)
    else $error("device drives data after not-acknowledge");
  a_ack_hold: assert property (rise && sdaDevOe |-> (sdaDevOe && !sda)[*8])
    else $error("device low level not held through clock high");
  a_dev_edge: assert property ($changed(sdaDevOe) |-> !scl)
    else $error("device changed data while clock high");
  a_start_free: assert property (startEv |-> !sdaDevOe)
    else $error("device holds data at a start");
  a_high_stable: assert property (rise |-> (scl && $stable(sda))[*8])
    else $error("data moved early in clock high phase");

  c_hit: cover property (ackSlot && first_ff && hit_ff);
  c_miss: cover property (ackSlot && first_ff && !hit_ff);
  c_nack: cover property (nack_ff && stopEv);
endmodule // rtc_i2c_slave_interface_assertions
`default_nettype wire

// ### rtc_i2c_slave_interface_test.sv
// Bench joining the host end and the clock device over the two-wire link.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_i2c_defs.svh"
module rtc_i2c_slave_interface_test
  import rtc_i2c_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic        cmdValid;
  mst_op_type  cmdOp;
  logic [7:0]  cmdData;
  logic        cmdNack;
  logic        cmdReady;
  logic        rspValid;
  logic [7:0]  rspData;
  logic        rspAck;
  logic        busIdle;
  logic        wrStrobe;
  logic [3:0]  wrAddr;
  logic [7:0]  wrData;
  logic        snapReq;
  logic        divReset;
  logic        openXfer;
  logic [3:0]  ptrM;
  logic [7:0]  img [0:9];
  logic [12:0] wq [$];
  int          mismatches = 0;
  int          compares = 0;
  int          snapCnt = 0;

  i2c_link_if i2c_link_if_i ();
  rtc_i2c_host rtc_i2c_host_i (.sys_clk(sys_clk), .rst(rst), .link(i2c_link_if_i),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData), .cmdNack(cmdNack),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspAck(rspAck),
    .busIdle(busIdle));
  rtc_i2c_device rtc_i2c_device_i (.sys_clk(sys_clk), .rst(rst), .link(i2c_link_if_i),
    .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData), .snapReq(snapReq),
    .divReset(divReset));
  rtc_i2c_slave_interface_assertions rtc_i2c_slave_interface_assertions_i (.sys_clk(sys_clk),
    .rst(rst), .sdaDevOe(i2c_link_if_i.sdaDevOe), .scl(i2c_link_if_i.scl),
    .sda(i2c_link_if_i.sda));

  // Free-running system clock.
  always #20 sys_clk = !sys_clk;

  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Device pulses are logged as they come; scenarios judge them once the frame is over.
  always @(posedge sys_clk)
  begin
    if (wrStrobe === 1'b1)
      wq.push_back({divReset, wrAddr, wrData});
    if (snapReq === 1'b1)
      snapCnt++;
    if (divReset === 1'b1 && wrStrobe !== 1'b1)
      chk("lone divReset", 13'h0, 13'h1);
  end

  // One host command: held until taken, then bounded waits for its completion.
  task automatic cmd(input mst_op_type op, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    cmdOp <= op;
    cmdData <= d;
    cmdNack <= nk;
    cmdValid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (!(cmdReady === 1'b1 && (op != OP_START || busIdle === 1'b1 || openXfer))
           && n < 400);
    cmdValid <= 1'b0;
    openXfer = (op == OP_START) || (openXfer && op != OP_STOP);
    if (n >= 400)
      chk("take", 13'h1, 13'h0);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (((op == OP_WRITE || op == OP_READ) ? rspValid : cmdReady) !== 1'b1 && n < 800);
    if (n >= 800)
      chk("done", 13'h1, 13'h0);
    if (op == OP_STOP)
      repeat (6) @(posedge sys_clk);
  endtask

  task automatic put(input logic [7:0] d, input logic expAck);
    cmd(OP_WRITE, d, 1'b0);
    chk("ack", {12'h0, expAck}, {12'h0, rspAck});
  endtask

  // Read n bytes, optionally after a pointer write joined by a repeated START.
  task automatic rd_burst(input logic setPtr, input logic [3:0] p, input int n);
    cmd(OP_START, 8'h00, 1'b0);
    if (setPtr)
    begin
      put(8'hD0, 1'b1);
      put({4'h0, p}, 1'b1);
      // A pointer byte beyond the map lands on the first register.
      ptrM = (p > `REG_LAST) ? `REG_FIRST : p;
      cmd(OP_START, 8'h00, 1'b0);
    end
    put(8'hD1, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      cmd(OP_READ, 8'h00, i == n - 1);
      chk("read byte", {5'h0, img[ptrM]}, {5'h0, rspData});
      ptrM = (ptrM == `REG_LAST) ? `REG_FIRST : ptrM + 4'h1;
    end
    cmd(OP_STOP, 8'h00, 1'b0);
  endtask

  // Write a burst; the commit log must match address, data and divider reset.
  task automatic wr_burst(input logic [3:0] p, input logic [7:0] dat [$]);
    logic [12:0] exq [$];
    cmd(OP_START, 8'h00, 1'b0);
    put(8'hD0, 1'b1);
    put({4'h0, p}, 1'b1);
    ptrM = p;
    foreach (dat[i])
    begin
      put(dat[i], 1'b1);
      img[ptrM] = dat[i];
      exq.push_back({ptrM == `REG_SECONDS || ptrM == `REG_CONTROL, ptrM, dat[i]});
      ptrM = (ptrM == `REG_LAST) ? `REG_FIRST : ptrM + 4'h1;
    end
    cmd(OP_STOP, 8'h00, 1'b0);
    foreach (exq[i])
      chk("commit", exq[i], (wq.size() > 0) ? wq.pop_front() : 13'h1FFF);
    chk("extra commits", 13'h0, 13'(wq.size()));
  endtask

  task automatic t_reset_regs();
    int s0;
    s0 = snapCnt;
    rd_burst(1'b1, 4'h0, 11);
    chk("snapshots", 13'h4, 13'(snapCnt - s0));
    chk("reads commit", 13'h0, 13'(wq.size()));
    chk("bus idle", 13'h1, {12'h0, busIdle});
  endtask

  // Burst across the top of the map, then a read that relies on the stale pointer.
  task automatic t_write_wrap();
    int s0;
    s0 = snapCnt;
    wr_burst(4'h6, '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h77});
    chk("snapshots", 13'h3, 13'(snapCnt - s0));
    wr_burst(4'h9, '{8'h44});
    rd_burst(1'b0, 4'h0, 10);
  endtask

  // Near-miss addresses (last and first address bit wrong) must be ignored.
  task automatic t_bad_addr();
    logic [7:0] bad [2];
    bad = '{8'hD2, 8'h50};
    for (int i = 0; i < 2; i++)
    begin
      cmd(OP_START, 8'h00, 1'b0);
      put(bad[i], 1'b0);
      put(8'h00, 1'b0);
      cmd(OP_STOP, 8'h00, 1'b0);
    end
    chk("ignored writes", 13'h0, 13'(wq.size()));
    rd_burst(1'b0, 4'h0, 2);
    rd_burst(1'b1, 4'hC, 1);
  endtask

  // Reset, then the scenarios in order.
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = OP_START;
    cmdData = 8'h00;
    cmdNack = 1'b0;
    openXfer = 1'b0;
    ptrM = 4'h0;
    foreach (img[i])
      img[i] = (i == 7) ? `CTRL_RESET : `REG_RESET;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_regs();
    t_write_wrap();
    t_bad_addr();
    tally_and_finish();
  end

  // Watchdog; the scenarios need about 30000 cycles, so this leaves wide margin.
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    chk("watchdog", 13'h0, 13'h1);
    tally_and_finish();
  end
endmodule // rtc_i2c_slave_interface_test
`default_nettype wire
